// file: pkg/dvtc_pkg.sv
// shared constants and carrier types for the dual vector table compare block
package dvtc_pkg;
   localparam int          VEC_ADDR_W        = 7;
   localparam int          VEC_DATA_W        = 32;
   localparam int          TRIP_W            = 8;
   localparam logic [31:0] DEFAULT_HANDLER   = 32'h003fffbe;
   localparam logic [31:0] HANDLER_RESET_VAL = 32'h00000000;
   localparam logic        PROGRAMMED_RESET  = 1'b0;

   typedef enum logic [1:0] {
      DVTC_WR_NONE,
      DVTC_WR_BOTH,
      DVTC_WR_COPY_A,
      DVTC_WR_COPY_B
   } dvtc_wr_kind_type;

   typedef struct packed {
      dvtc_wr_kind_type        kind;
      logic [VEC_ADDR_W-1:0]   addr;
      logic [VEC_DATA_W-1:0]   data;
   } dvtc_wr_type;

   typedef struct packed {
      logic                    valid;
      logic [VEC_DATA_W-1:0]   target;
      logic                    mismatch;
   } dvtc_fetch_rsp_type;
endpackage

// file: rtl/dvtc_dual_vector_table_compare.sv
// duplicated vector table with compare on every fetch and error redirect
// Notes on behaviour
// - normal writes store data in both copies
// - each fetch reads and compares both copies
// - mismatch returns programmed error handler address
// - mismatch also raises trip towards modulators
// - unprogrammed handler register gives fixed default
// - alias write updates only one copy
`timescale 1ns/100ps
module dvtc_dual_vector_table_compare
   import dvtc_pkg::*;
#(
   parameter int NUM_VEC = 128
)(
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   // table write port
   input  wire dvtc_wr_type           tableWrite,
   // error handler address write
   input  wire logic                  handlerWrite,
   input  wire logic [31:0]           handlerData,
   // vector fetch
   input  wire logic                  fetchReq,
   input  wire logic [VEC_ADDR_W-1:0] fetchAddr,
   output dvtc_fetch_rsp_type         fetchRsp,
   // trip towards modulators, held until cleared
   input  wire logic                  tripClear,
   output logic [TRIP_W-1:0]          pwmTrip
);

   // refused at elaboration: the table must hold 1 to 128 entries so the index can reach all of them
   if (NUM_VEC < 1 || NUM_VEC > (1 << VEC_ADDR_W))
   begin : g_bad_num_vec
      $error("NUM_VEC does not fit the vector address width");
   end
   // the target carries either a vector or a handler address, so widths match
   if (VEC_DATA_W != 32)
   begin : g_bad_data_w
      $error("vector width must match the handler address width");
   end

   ////////////////////////////////////////////////////////////////////////////
   // two copies, no reset: contents are software initialised
   logic [VEC_DATA_W-1:0] copyA [NUM_VEC];
   logic [VEC_DATA_W-1:0] copyB [NUM_VEC];
   logic [31:0]           handlerAddr;
   logic                  programmed;

   // one decoder for both copies keeps the alias map in a single place
   // copySel high picks copy b; an alias write must leave the other copy alone
   function automatic logic writes_copy(input dvtc_wr_kind_type kind, input logic copySel);
      logic hit;
      hit = (kind == DVTC_WR_BOTH);
      if (copySel)
         hit = hit || (kind == DVTC_WR_COPY_B);
      else
         hit = hit || (kind == DVTC_WR_COPY_A);
      return hit;
   endfunction

   always_ff @(posedge clk_sys)
   begin
      if (writes_copy(tableWrite.kind, 1'b0))
         copyA[tableWrite.addr] <= tableWrite.data;
      if (writes_copy(tableWrite.kind, 1'b1))
         copyB[tableWrite.addr] <= tableWrite.data;
   end

   ////////////////////////////////////////////////////////////////////////////
   // any write counts as programmed, even zero, so zero is a legal handler
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         handlerAddr <= HANDLER_RESET_VAL;
         programmed  <= PROGRAMMED_RESET;
      end
      else if (handlerWrite)
      begin
         handlerAddr <= handlerData;
         programmed  <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare sits on the read ports, so the answer costs one cycle only
   logic [VEC_DATA_W-1:0] rdA;
   logic [VEC_DATA_W-1:0] rdB;
   logic                  differ;
   logic [31:0]           errTarget;

   always_comb
   begin
      rdA       = copyA[fetchAddr];
      rdB       = copyB[fetchAddr];
      differ    = (rdA != rdB);
      errTarget = programmed ? handlerAddr : DEFAULT_HANDLER;
   end

   // target holds on idle cycles; valid and mismatch are one-cycle pulses
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         fetchRsp <= '0;
      else
      begin
         fetchRsp.valid    <= fetchReq;
         fetchRsp.mismatch <= fetchReq && differ;
         if (fetchReq)
            fetchRsp.target <= differ ? errTarget : rdA;
      end
   end

   // trip stays until cleared so a short fetch cannot be missed; set wins
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         pwmTrip <= '0;
      else if (fetchReq && differ)
         pwmTrip <= '1;
      else if (tripClear)
         pwmTrip <= '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // fetch response: redirect on mismatch, vector passed through otherwise
   // a handler write in the fetch cycle only applies to the next fetch
   a_mismatch_redirects: assert property (@(posedge clk_sys) disable iff (sys_rst)
      fetchReq && differ |=> fetchRsp.valid && fetchRsp.mismatch
         && fetchRsp.target == $past(errTarget))
      else $error("mismatch did not redirect");

   a_match_passes_vector: assert property (@(posedge clk_sys) disable iff (sys_rst)
      fetchReq && !differ |=> fetchRsp.valid && !fetchRsp.mismatch
         && fetchRsp.target == $past(rdA))
      else $error("matching fetch altered");

   a_default_handler: assert property (@(posedge clk_sys) disable iff (sys_rst)
      fetchReq && differ && !programmed |=> fetchRsp.target == DEFAULT_HANDLER)
      else $error("default handler not used");

   a_programmed_target: assert property (@(posedge clk_sys) disable iff (sys_rst)
      fetchReq && differ && programmed |=> fetchRsp.target == $past(handlerAddr))
      else $error("programmed handler not used");

   a_pulse_needs_fetch: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !fetchReq |=> !fetchRsp.valid && !fetchRsp.mismatch)
      else $error("response without fetch");

   a_target_stands: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !fetchReq |=> $stable(fetchRsp.target))
      else $error("target changed without fetch");

   a_mismatch_in_valid: assert property (@(posedge clk_sys) disable iff (sys_rst)
      fetchRsp.mismatch |-> fetchRsp.valid)
      else $error("mismatch outside a response");

   ////////////////////////////////////////////////////////////////////////////
   // trip: raised only by a mismatch, dropped only by a clear
   // a clear in the mismatch cycle loses, so no trip is ever swallowed
   a_trip_on_mismatch: assert property (@(posedge clk_sys) disable iff (sys_rst)
      fetchReq && differ |=> pwmTrip == '1 [*1])
      else $error("trip not raised");

   a_trip_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pwmTrip != '0 && !tripClear |=> pwmTrip != '0)
      else $error("trip dropped without clear");

   a_trip_needs_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(|pwmTrip) |-> $past(fetchReq && differ))
      else $error("trip raised without mismatch");

   a_clear_drops_trip: assert property (@(posedge clk_sys) disable iff (sys_rst)
      tripClear && !(fetchReq && differ) |=> pwmTrip == '0)
      else $error("clear did not drop trip");

   ////////////////////////////////////////////////////////////////////////////
   // handler register and its programmed flag
   // only reset may bring the flag back to the default handler
   a_programmed_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      handlerWrite |=> programmed && handlerAddr == $past(handlerData))
      else $error("handler write not taken");

   a_programmed_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(programmed) |-> $past(handlerWrite))
      else $error("programmed set without write");

   a_handler_stable: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !handlerWrite |=> $stable(handlerAddr) && $stable(programmed))
      else $error("handler changed without write");

   ////////////////////////////////////////////////////////////////////////////
   // table copies: the written copy takes the data, the other keeps its past
   // entries never written stay unknown, so only written entries are watched
   a_both_written: assert property (@(posedge clk_sys) disable iff (sys_rst)
      tableWrite.kind == DVTC_WR_BOTH ##1 fetchReq && fetchAddr == $past(tableWrite.addr)
         && tableWrite.kind == DVTC_WR_NONE |-> !differ)
      else $error("copies differ after normal write");

   a_copy_a_written: assert property (@(posedge clk_sys) disable iff (sys_rst)
      writes_copy(tableWrite.kind, 1'b0)
         |=> copyA[$past(tableWrite.addr)] == $past(tableWrite.data))
      else $error("table write missed copy a");

   a_copy_b_written: assert property (@(posedge clk_sys) disable iff (sys_rst)
      writes_copy(tableWrite.kind, 1'b1)
         |=> copyB[$past(tableWrite.addr)] == $past(tableWrite.data))
      else $error("table write missed copy b");

   a_alias_one_copy: assert property (@(posedge clk_sys) disable iff (sys_rst)
      tableWrite.kind == DVTC_WR_COPY_B |=> copyA[$past(tableWrite.addr)]
         == $past(copyA[tableWrite.addr]))
      else $error("alias write touched other copy");

   a_alias_keeps_b: assert property (@(posedge clk_sys) disable iff (sys_rst)
      tableWrite.kind == DVTC_WR_COPY_A |=> copyB[$past(tableWrite.addr)]
         == $past(copyB[tableWrite.addr]))
      else $error("alias write touched copy b");

endmodule // dvtc_dual_vector_table_compare

// file: verification/dvtc_dual_vector_table_compare_tb_top.sv
// testbench for the dual vector table compare block
`timescale 1ns/100ps
module dvtc_dual_vector_table_compare_tb_top
   import dvtc_pkg::*;
;
   logic                  clk_sys = 1'h0, sys_rst = 1'h1, handlerWrite = 1'h0;
   logic                  fetchReq = 1'h0, tripClear = 1'h0, safeState;
   dvtc_wr_type           tableWrite = '0;
   logic [31:0]           handlerData = 32'h0;
   logic [VEC_ADDR_W-1:0] fetchAddr = 7'h0;
   dvtc_fetch_rsp_type    fetchRsp;
   logic [TRIP_W-1:0]     pwmTrip;
   int                    failures = 0, comparisons = 0, cycles = 0;
   always #4 clk_sys = ~clk_sys;
   dvtc_dual_vector_table_compare u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .tableWrite(tableWrite), .handlerWrite(handlerWrite), .handlerData(handlerData),
      .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchRsp(fetchRsp),
      .tripClear(tripClear), .pwmTrip(pwmTrip));
   dvtc_pwm_model u_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .pwmTrip(pwmTrip),
      .safeState(safeState));
////////////////////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wr(input dvtc_wr_kind_type k, input logic [6:0] a, input logic [31:0] d);
      @(posedge clk_sys) tableWrite <= '{k, a, d};
      @(posedge clk_sys) tableWrite.kind <= DVTC_WR_NONE;
   endtask
   // trip is sticky, so the expected level is passed in
   task fetch(input logic [6:0] a, input logic [31:0] t, input logic m, input logic [7:0] p);
      @(posedge clk_sys) fetchReq <= 1'h1;
      fetchAddr <= a;
      @(posedge clk_sys) fetchReq <= 1'h0;
      #1 chk("valid", 32'h1, fetchRsp.valid);
      chk("target", t, fetchRsp.target);
      chk("mismatch", m, fetchRsp.mismatch);
      chk("trip", p, pwmTrip);
      @(posedge clk_sys) #1 chk("valid drop", 32'h0, fetchRsp.valid);
      chk("mismatch drop", 32'h0, fetchRsp.mismatch);
      chk("target held", t, fetchRsp.target);
   endtask
   task clear_trip;
      @(posedge clk_sys) tripClear <= 1'h1;
      @(posedge clk_sys) tripClear <= 1'h0;
      #1 chk("trip cleared", 32'h0, pwmTrip);
   endtask
////////////////////////////////////////////////////////////////////////////////
   task test_default_redirect;
      wr(DVTC_WR_BOTH, 7'h09, 32'h0000_1111);
      wr(DVTC_WR_COPY_B, 7'h09, 32'h0000_2222);
      fetch(7'h09, DEFAULT_HANDLER, 1'h1, 8'hff);
      @(posedge clk_sys) #1 chk("safe state", 32'h1, safeState);
      clear_trip();
   endtask
   task test_programmed_redirect;
      @(posedge clk_sys) handlerWrite <= 1'h1;
      handlerData <= 32'h0000_9abc;
      @(posedge clk_sys) handlerWrite <= 1'h0;
      wr(DVTC_WR_BOTH, 7'h7f, 32'h0000_3333);
      wr(DVTC_WR_COPY_A, 7'h7f, 32'h0000_3332);
      fetch(7'h7f, 32'h0000_9abc, 1'h1, 8'hff);
      clear_trip();
   endtask
   task test_write_then_fetch;
      @(posedge clk_sys) tableWrite <= '{DVTC_WR_BOTH, 7'h05, 32'h0000_5555};
      @(posedge clk_sys) tableWrite.kind <= DVTC_WR_NONE;
      fetchReq <= 1'h1;
      fetchAddr <= 7'h05;
      @(posedge clk_sys) fetchReq <= 1'h0;
      #1 chk("next cycle target", 32'h0000_5555, fetchRsp.target);
      chk("next cycle mismatch", 32'h0, fetchRsp.mismatch);
   endtask
   // clear loses to a mismatch in one cycle; reset forgets the handler, not the table
   task test_clear_and_reset;
      @(posedge clk_sys) fetchReq <= 1'h1;
      fetchAddr <= 7'h7f;
      tripClear <= 1'h1;
      @(posedge clk_sys) fetchReq <= 1'h0;
      tripClear <= 1'h0;
      #1 chk("trip beats clear", 32'hff, pwmTrip);
      chk("programmed target", 32'h0000_9abc, fetchRsp.target);
      @(posedge clk_sys) sys_rst <= 1'h1;
      @(posedge clk_sys) #1 chk("trip in reset", 32'h0, pwmTrip);
      chk("valid in reset", 32'h0, fetchRsp.valid);
      @(posedge clk_sys) sys_rst <= 1'h0;
      fetch(7'h7f, DEFAULT_HANDLER, 1'h1, 8'hff);
      clear_trip();
   endtask
////////////////////////////////////////////////////////////////////////////////
   task give_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 400)
      begin
         failures++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'h0;
      #1 chk("trip after reset", 32'h0, pwmTrip);
      wr(DVTC_WR_BOTH, 7'h00, 32'h0000_1234);
      fetch(7'h00, 32'h0000_1234, 1'h0, 8'h00);
      test_default_redirect();
      test_programmed_redirect();
      test_write_then_fetch();
      test_clear_and_reset();
      fetch(7'h00, 32'h0000_1234, 1'h0, 8'h00);
      give_verdict();
   end
endmodule // dvtc_dual_vector_table_compare_tb_top

// file: verification/dvtc_pwm_model.sv
// modulator trip input model whose safe state follows the trip one cycle later
`timescale 1ns/100ps
module dvtc_pwm_model
   import dvtc_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   // trip in, safe state out
   input  wire logic [TRIP_W-1:0] pwmTrip,
   output logic                   safeState
);
   always_ff @(posedge clk_sys or posedge sys_rst)
      if (sys_rst)
         safeState <= 1'h0;
      else
         safeState <= |pwmTrip;
endmodule // dvtc_pwm_model
